// file: pin_irq_pkg.sv
// constants for the bank-1 pin interrupt block: register map, field layout, reset values
// assumes a 32-bit AXI4-Lite register port with 12 byte-address bits
// Function
// [RULE1] one sticky status bit per pin, bits 21:0
// [RULE2] write one clears status, zero leaves it
// [RULE3] bits 31:22 ignored on write, no effect
// [RULE4] type bit: 0 level, 1 edge sensitive
// [RULE5] polarity: 0 low/falling, 1 high/rising
// [RULE6] any-edge bit: 1 triggers on both edges
// [RULE7] bit n serves pin 32+n of bank
// [RULE8] software: mask, clear, configure, then enable
// [RULE9] enable write of one unmasks that pin
// [RULE10] irq output while any unmasked status set
package pin_irq_pkg;
  localparam int NPINS = 22;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 12'h250;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK_WRITE = 12'h254;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h258;
  localparam logic [ADDR_W-1:0] OFF_IRQ_LEVEL_OR_EDGE = 12'h25C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_POLARITY = 12'h260;
  localparam logic [ADDR_W-1:0] OFF_IRQ_BOTH_EDGES = 12'h264;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK_READ = 12'h268;
  localparam logic [ADDR_W-1:0] OFF_PIN_LEVEL = 12'h26C;
  localparam logic [NPINS-1:0] CFG_RESET = 22'h000000;
  localparam logic [NPINS-1:0] STATUS_RESET = 22'h000000;
  localparam logic [NPINS-1:0] MASK_RESET = 22'h3FFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;
endpackage : pin_irq_pkg

// file: pin_evt_if.sv
// carries pin configuration to the detector and detected events back
// assumes both ends share ref_clk
`timescale 1ns/1ps
interface pin_evt_if;
  import pin_irq_pkg::*;
  logic [NPINS-1:0] edgeSel;
  logic [NPINS-1:0] polHigh;
  logic [NPINS-1:0] bothEdges;
  logic [NPINS-1:0] evt;
  logic [NPINS-1:0] pinLevel;
  modport ctrl (output edgeSel, output polHigh, output bothEdges, input evt, input pinLevel);
  modport det (input edgeSel, input polHigh, input bothEdges, output evt, output pinLevel);
endinterface : pin_evt_if

// file: pin_detect.sv
// per-pin synchroniser and level/edge event detector
// assumes pins are asynchronous to ref_clk; one cycle of event per detected edge
`timescale 1ns/1ps
module pin_detect
  import pin_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NPINS-1:0] pinIn,
  pin_evt_if.det cfg
);
  logic [NPINS-1:0] syncA_r;
  logic [NPINS-1:0] syncB_r;
  logic [NPINS-1:0] syncC_r;
  logic [NPINS-1:0] lvl_r;
  logic [NPINS-1:0] lvl_nxt;
  logic [NPINS-1:0] evt_r;
  logic [2:0] settle_r;
  // the flops start at zero, not at the pin level: no events until real levels fill them
  wire warm = settle_r[2];
  wire [NPINS-1:0] agree = ~(syncB_r ^ syncC_r);
  wire [NPINS-1:0] rise = lvl_nxt & ~lvl_r;
  wire [NPINS-1:0] fall = ~lvl_nxt & lvl_r;
  // level match follows polarity; edge match picks one edge or both
  wire [NPINS-1:0] lvlHit = ~(lvl_nxt ^ cfg.polHigh); // [RULE5]
  wire [NPINS-1:0] edgeOne = (cfg.polHigh & rise) | (~cfg.polHigh & fall); // [RULE5]
  wire [NPINS-1:0] edgeAny = (cfg.bothEdges & (rise | fall)) | (~cfg.bothEdges & edgeOne); // [RULE6]
  wire [NPINS-1:0] evt_nxt = (cfg.edgeSel & edgeAny) | (~cfg.edgeSel & lvlHit); // [RULE4]

  ////////////////////////////////////////////////////////////////////////////
  // once warm, a level only counts when two late stages agree, filtering metastable settle
  assign lvl_nxt = warm ? ((agree & syncB_r) | (~agree & lvl_r)) : syncB_r;
  assign cfg.evt = evt_r;
  assign cfg.pinLevel = lvl_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncA_r <= CFG_RESET;
      syncB_r <= CFG_RESET;
      syncC_r <= CFG_RESET;
      lvl_r <= CFG_RESET;
      evt_r <= CFG_RESET;
      settle_r <= 3'h0;
    end else begin
      settle_r <= {settle_r[1:0], 1'b1};
      syncA_r <= pinIn;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      lvl_r <= lvl_nxt;
      evt_r <= evt_nxt & {NPINS{warm}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  riseEvent_a: assert property ((warm && cfg.edgeSel[0] && cfg.polHigh[0] && !cfg.bothEdges[0]
      && rise[0]) |=> evt_r[0]) else $error("rising edge missed"); // [RULE5]
  singleEdge_a: assert property ((cfg.edgeSel[0] && cfg.polHigh[0] && !cfg.bothEdges[0]
      && fall[0]) |=> !evt_r[0]) else $error("wrong edge fired"); // [RULE6]
  bothEdge_a: assert property ((warm && cfg.edgeSel[5] && cfg.bothEdges[5] && (rise[5] || fall[5]))
      |=> evt_r[5]) else $error("any-edge missed"); // [RULE6]
  levelLow_a: assert property ((warm && !cfg.edgeSel[2] && !cfg.polHigh[2] && !lvl_nxt[2])
      |=> evt_r[2]) else $error("low level missed"); // [RULE4]
endmodule : pin_detect

// file: pin_bank_irq.sv
// bank-1 pin interrupt block: AXI4-Lite register slave, sticky status, mask, irq output
// assumes one AXI4-Lite master, single outstanding read and write, async pins
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pin_bank_irq
  import pin_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPINS-1:0] pinIn,
  output logic irqOut
);
  function automatic logic hitReg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction : hitReg

  // byte lanes reduced to the 22 implemented bits; upper bits are dropped here
  function automatic logic [NPINS-1:0] laneBits(input logic [DATA_W-1:0] d,
                                                input logic [3:0] s);
    logic [DATA_W-1:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return NPINS'(d & m); // [RULE3]
  endfunction : laneBits

  function automatic logic [NPINS-1:0] mergeRw(input logic [NPINS-1:0] old,
                                               input logic [DATA_W-1:0] d,
                                               input logic [3:0] s);
    logic [NPINS-1:0] m;
    m = laneBits(32'hFFFFFFFF, s);
    return (old & ~m) | (NPINS'(d) & m);
  endfunction : mergeRw

  pin_evt_if cfgBus ();

  pin_detect detect (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(pinIn),
    .cfg(cfgBus.det)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data latched independently, acted on together
  logic awHeld_r;
  logic wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [DATA_W-1:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  wire awTake = s_axi_awvalid & ~awHeld_r;
  wire wTake = s_axi_wvalid & ~wHeld_r;
  wire doWrite = awHeld_r & wHeld_r & ~bValid_r;
  wire [NPINS-1:0] wBits = laneBits(wData_r, wStrb_r);
  wire wrEnable = doWrite & hitReg(awAddr_r, OFF_IRQ_ENABLE);
  wire wrMaskSet = doWrite & hitReg(awAddr_r, OFF_IRQ_MASK_WRITE);
  wire wrStatus = doWrite & hitReg(awAddr_r, OFF_IRQ_STATUS);
  wire wrType = doWrite & hitReg(awAddr_r, OFF_IRQ_LEVEL_OR_EDGE);
  wire wrPol = doWrite & hitReg(awAddr_r, OFF_IRQ_POLARITY);
  wire wrAny = doWrite & hitReg(awAddr_r, OFF_IRQ_BOTH_EDGES);
  wire wrReadOnly = doWrite & (hitReg(awAddr_r, OFF_IRQ_MASK_READ)
                    | hitReg(awAddr_r, OFF_PIN_LEVEL));
  wire wrMapped = wrEnable | wrMaskSet | wrStatus | wrType | wrPol | wrAny | wrReadOnly;

  assign s_axi_awready = ~awHeld_r;
  assign s_axi_wready = ~wHeld_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 12'h000;
      wData_r <= READ_ZERO;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else begin
      if (awTake) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (wTake) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
      if (doWrite) begin
        bValid_r <= 1'b1;
        bResp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, mask and sticky status
  logic [NPINS-1:0] type_r;
  logic [NPINS-1:0] pol_r;
  logic [NPINS-1:0] any_r;
  logic [NPINS-1:0] mask_r;
  logic [NPINS-1:0] stat_r;
  logic irq_r;
  wire [NPINS-1:0] type_nxt = wrType ? mergeRw(type_r, wData_r, wStrb_r) : type_r; // [RULE4]
  wire [NPINS-1:0] pol_nxt = wrPol ? mergeRw(pol_r, wData_r, wStrb_r) : pol_r; // [RULE5]
  wire [NPINS-1:0] any_nxt = wrAny ? mergeRw(any_r, wData_r, wStrb_r) : any_r; // [RULE6]
  wire [NPINS-1:0] unmask = wrEnable ? wBits : 22'h000000; // [RULE9]
  wire [NPINS-1:0] maskSet = wrMaskSet ? wBits : 22'h000000;
  // a disable in the same write cannot collide with an enable; separate offsets
  wire [NPINS-1:0] mask_nxt = (mask_r & ~unmask) | maskSet; // [RULE9]
  wire [NPINS-1:0] statClr = wrStatus ? wBits : 22'h000000; // [RULE2]
  // a new event outranks a clear in the same cycle so nothing is lost
  wire [NPINS-1:0] stat_nxt = (stat_r & ~statClr) | cfgBus.evt; // [RULE1] [RULE7]
  wire irq_nxt = |(stat_nxt & ~mask_nxt); // [RULE10]

  assign cfgBus.edgeSel = type_r;
  assign cfgBus.polHigh = pol_r;
  assign cfgBus.bothEdges = any_r;
  assign irqOut = irq_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      type_r <= CFG_RESET;
      pol_r <= CFG_RESET;
      any_r <= CFG_RESET;
      mask_r <= MASK_RESET;
      stat_r <= STATUS_RESET;
      irq_r <= 1'b0;
    end else begin
      type_r <= type_nxt;
      pol_r <= pol_nxt;
      any_r <= any_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel; write-only registers read zero, upper bits always zero
  logic rValid_r;
  logic [DATA_W-1:0] rData_r;
  logic [1:0] rResp_r;
  wire arTake = s_axi_arvalid & ~rValid_r;
  wire rdStat = hitReg(s_axi_araddr, OFF_IRQ_STATUS);
  wire rdType = hitReg(s_axi_araddr, OFF_IRQ_LEVEL_OR_EDGE);
  wire rdPol = hitReg(s_axi_araddr, OFF_IRQ_POLARITY);
  wire rdAny = hitReg(s_axi_araddr, OFF_IRQ_BOTH_EDGES);
  wire rdMask = hitReg(s_axi_araddr, OFF_IRQ_MASK_READ);
  wire rdLevel = hitReg(s_axi_araddr, OFF_PIN_LEVEL);
  wire rdWo = hitReg(s_axi_araddr, OFF_IRQ_ENABLE) | hitReg(s_axi_araddr, OFF_IRQ_MASK_WRITE);
  wire rdMapped = rdStat | rdType | rdPol | rdAny | rdMask | rdLevel | rdWo;
  wire [NPINS-1:0] rdBits = ({NPINS{rdStat}} & stat_r) | ({NPINS{rdType}} & type_r)
                          | ({NPINS{rdPol}} & pol_r) | ({NPINS{rdAny}} & any_r)
                          | ({NPINS{rdMask}} & mask_r) | ({NPINS{rdLevel}} & cfgBus.pinLevel);

  assign s_axi_arready = ~rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rValid_r <= 1'b0;
      rData_r <= READ_ZERO;
      rResp_r <= RESP_OKAY;
    end else if (arTake) begin
      rValid_r <= 1'b1;
      rData_r <= {10'h000, rdBits}; // [RULE1] [RULE3]
      rResp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  statSticky_a: assert property ((stat_r[21] && !(wrStatus && wBits[21])) |=> stat_r[21])
    else $error("status bit dropped"); // [RULE1]
  clearOne_a: assert property ((wrStatus && wBits[4] && !cfgBus.evt[4]) |=> !stat_r[4])
    else $error("status not cleared"); // [RULE2]
  clearZero_a: assert property ((wrStatus && !wBits[5] && stat_r[5]) |=> stat_r[5])
    else $error("zero write cleared status"); // [RULE2]
  setWins_a: assert property (cfgBus.evt[10] |=> stat_r[10])
    else $error("event lost under clear"); // [RULE1]
  upperZero_a: assert property (rValid_r |-> rData_r[31:22] == 10'h000)
    else $error("upper read bits set"); // [RULE3]
  statRead_a: assert property ((arTake && rdStat) |=> rData_r[21:0] == $past(stat_r))
    else $error("status read wrong"); // [RULE7]
  enableMask_a: assert property ((wrEnable && wBits[7] && !wrMaskSet) |=> !mask_r[7])
    else $error("enable did not unmask"); // [RULE9]
  irqTie_a: assert property ((|(stat_r & ~mask_r)) == irqOut)
    else $error("irq output mismatch"); // [RULE10]
  writeAnswer_a: assert property (doWrite |=> bValid_r ##0 (awHeld_r == 1'b0))
    else $error("write answer missing");

  writeDone_c: cover property (bValid_r && s_axi_bready && bResp_r == RESP_OKAY);
  readDone_c: cover property (rValid_r && s_axi_rready && rResp_r == RESP_OKAY);
  irqRise_c: cover property (!irqOut ##1 irqOut);
  clearRace_c: cover property (wrStatus && |(wBits & cfgBus.evt));
endmodule : pin_bank_irq

// file: pin_source.sv
// external signal sources standing on the bank-1 multiplexed pins
// assumes pin levels change with no relation to ref_clk
`timescale 1ns/1ps
module pin_source
  import pin_irq_pkg::*;
(
  input wire logic [NPINS-1:0] levelWant,
  output logic [NPINS-1:0] pinIn
);
  initial pinIn = '1;
  // bit n drives pin 32+n; the lag keeps edges off the sampling edge, as a real source would
  always @(levelWant) pinIn <= #3 levelWant;
endmodule : pin_source

// file: tb.sv
// self-checking bench for the bank-1 pin interrupt block over AXI4-Lite
// assumes the pin_source model on the pins and a 100 MHz ref_clk
`timescale 1ns/1ps
module tb;
  import pin_irq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irqOut;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [DATA_W-1:0] s_axi_rdata, rdVal;
  logic [NPINS-1:0] pinIn;
  logic [NPINS-1:0] levelWant = '1;
  int error_cnt = 0;
  int checks = 0;
  always #5 ref_clk = ~ref_clk;
  pin_bank_irq i_dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinIn, .irqOut);
  pin_source i_pins (.levelWant, .pinIn);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string m);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // a hung handshake ends the run rather than stalling it
  task automatic guard(input int n);
    if (n > 50) begin
      error_cnt++;
      $display("MISMATCH %0t bus handshake timed out", $time);
      print_verdict();
    end
  endtask : guard
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      guard(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string m);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      guard(n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rdVal = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rdVal, e, m);
  endtask : rdchk
  task automatic irqChk(input logic e, input string m);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irqOut}, {31'h0, e}, m);
  endtask : irqChk
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdchk(OFF_IRQ_STATUS + ADDR_W'(4 * i), 32'h00000000, "reset value");
    end
    rdchk(OFF_IRQ_MASK_READ, 32'h003FFFFF, "mask reset");
    // bring-up order: mask all, clear all, configure, then unmask
    wr(OFF_IRQ_MASK_WRITE, 32'hFFFFFFFF);
    wr(OFF_IRQ_STATUS, 32'hFFFFFFFF);
    wr(OFF_IRQ_LEVEL_OR_EDGE, 32'hFFFFFFFF);
    rdchk(OFF_IRQ_LEVEL_OR_EDGE, 32'h003FFFFF, "type upper bits");
    wr(OFF_IRQ_POLARITY, 32'hFFC00001);
    rdchk(OFF_IRQ_POLARITY, 32'h00000001, "polarity upper bits");
    wr(OFF_IRQ_BOTH_EDGES, 32'h00000020);
    wr(OFF_IRQ_ENABLE, 32'h00000001);
    rdchk(OFF_IRQ_MASK_READ, 32'h003FFFFE, "unmask pin0");
    // falling edges on pins 0 (rising only), 5 (both) and 21 (falling only)
    levelWant <= 22'h1FFFDE;
    repeat (10) @(posedge ref_clk);
    rdchk(OFF_IRQ_STATUS, 32'h00200020, "falling edges");
    irqChk(1'b0, "irq with masked status only");
    wr(OFF_IRQ_STATUS, 32'h00000020);
    rdchk(OFF_IRQ_STATUS, 32'h00200000, "partial clear");
    levelWant <= '1;
    repeat (10) @(posedge ref_clk);
    rdchk(OFF_IRQ_STATUS, 32'h00200021, "rising edges");
    irqChk(1'b1, "irq on unmasked status");
    wr(OFF_IRQ_MASK_WRITE, 32'h00000001);
    irqChk(1'b0, "irq after mask");
    wr(OFF_IRQ_ENABLE, 32'h00000001);
    irqChk(1'b1, "irq after enable");
    wr(OFF_IRQ_STATUS, 32'hFFFFFFFF);
    rdchk(OFF_IRQ_STATUS, 32'h00000000, "clear all");
    irqChk(1'b0, "irq after clear");
    // pin 10 level high, pin 2 level low: clearing cannot stick while the level stays
    wr(OFF_IRQ_LEVEL_OR_EDGE, 32'h003FFBFB);
    wr(OFF_IRQ_POLARITY, 32'h00000401);
    wr(OFF_IRQ_ENABLE, 32'h00000400);
    repeat (10) @(posedge ref_clk);
    rdchk(OFF_IRQ_STATUS, 32'h00000400, "level high");
    wr(OFF_IRQ_STATUS, 32'h00000400);
    rdchk(OFF_IRQ_STATUS, 32'h00000400, "level re-set");
    irqChk(1'b1, "irq level");
    levelWant[10] <= 1'b0;
    repeat (10) @(posedge ref_clk);
    wr(OFF_IRQ_STATUS, 32'h00000400);
    rdchk(OFF_IRQ_STATUS, 32'h00000000, "level gone");
    irqChk(1'b0, "irq level gone");
    levelWant[2] <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rdchk(OFF_IRQ_STATUS, 32'h00000004, "level low");
    irqChk(1'b0, "irq masked level low");
    levelWant[2] <= 1'b1;
    repeat (10) @(posedge ref_clk);
    wr(OFF_IRQ_STATUS, 32'h00000004);
    rdchk(OFF_IRQ_STATUS, 32'h00000000, "level low gone");
    // unmapped place answers with an error and reads zero
    rdchk(12'h100, 32'h00000000, "unmapped read");
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read resp");
    wr(12'h100, 32'hFFFFFFFF);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write resp");
    print_verdict();
  end
endmodule : tb
